// [logic/ddrad_decode.sv]
// Address decode stage: bank select, leaf select, row/column mapping, regions.
// Assumes the configuration inputs are already synchronous and held stable.
`timescale 1ns/1ps
`default_nettype none
module ddrad_decode
   import ddrad_pkg::*;
(
   input  wire logic        sys_clk_in,            // 20 MHz clock
   input  wire logic        reset_n_in,            // Async reset, active low
   input  wire logic        req_in,                // Address valid strobe
   input  wire logic [31:0] addr_in,               // Internal bus address
   input  wire logic        burst_in,              // Advance column by one burst
   input  wire logic        precharge_in,          // Precharge-variant control
   input  wire logic [31:0] memory_control_word_in, // Control word, bit 2 = 32-bit bus
   input  wire logic [6:0]  memory_base_value_in,  // Base address bits 31:25
   input  wire logic [6:0]  bank0_upper_limit_in,  // Bank 0 limit, 32MB units
   input  wire logic [6:0]  bank1_upper_limit_in,  // Bank 1 limit, 32MB units
   input  wire logic [9:0]  narrow_region_size_in, // Narrow region size, MB
   input  wire logic [1:0]  row_w_sel_in,          // 0:12 1:13 2:14 row bits
   input  wire logic [1:0]  col_w_sel_in,          // 0:9 1:10 2:11 column bits
   output var  logic        hit_out,               // Address hits memory
   output var  logic [1:0]  cs_n_out,              // Chip selects, active low
   output var  logic [1:0]  leaf_out,              // Internal leaf selects
   output var  logic [13:0] row_out,               // Row address lines
   output var  logic [13:0] dram_address_lines_out, // Column address lines
   output var  logic        narrow_out,            // Access runs as 32-bit
   output var  logic        invalid_err_out,       // Invalid region error pulse
   output var  logic [3:0]  page_kb_log2_out,      // log2 of page size in KB
   output var  logic        unsupported_out        // Geometry not supported
);
   // ==================================================
   // State
   typedef struct packed {
      ddrad_out_s  o;
      logic        unsup;
      logic [6:0]  last_col;
   } ddrad_state_s;

   ddrad_state_s st_q, st_d;

   // Bank size exponent relative to 64MB: 0..4 for 64M..1G.
   function automatic logic [2:0] size_step(input logic [1:0] r, input logic [1:0] c);
      size_step = 3'(r) + 3'(c);
   endfunction

   function automatic ddrad_dec_e pick_dec(input logic [1:0] r, input logic [1:0] c);
      if (r == 2'h1 && c == 2'h0) pick_dec = DDRAD_DEC2;
      else if (r == 2'h2 && c == 2'h1) pick_dec = DDRAD_DEC3;
      else pick_dec = DDRAD_DEC1;
   endfunction

   logic        bus32;
   logic [2:0]  step;
   logic [4:0]  leaf_lsb;
   ddrad_dec_e  dec;
   logic [31:0] base_addr;
   logic [31:0] narrow_bytes;
   logic        in_b0;
   logic        in_b1;
   logic        bit31_ok;

   always_comb begin
      bus32        = memory_control_word_in[WIDTH_CTRL_BIT];
      step         = size_step(row_w_sel_in, col_w_sel_in);
      // Half bank size on a 32-bit bus shifts the leaf pair down one bit
      leaf_lsb     = 5'(LEAF_LSB_64M) + 5'(step) - 5'(bus32);
      dec          = pick_dec(row_w_sel_in, col_w_sel_in);
      base_addr    = {memory_base_value_in, 25'h0};
      narrow_bytes = {2'h0, narrow_region_size_in, 20'h0};
      bit31_ok     = addr_in[31] == memory_base_value_in[6];
      in_b0 = bit31_ok && addr_in[30:GRAN_LSB] >= memory_base_value_in[5:0]
              && {1'b0, addr_in[30:GRAN_LSB]} < bank0_upper_limit_in;
      in_b1 = bit31_ok && {1'b0, addr_in[30:GRAN_LSB]} >= bank0_upper_limit_in
              && {1'b0, addr_in[30:GRAN_LSB]} < bank1_upper_limit_in;
   end

   always_comb begin
      logic [31:0] off;
      off  = addr_in - base_addr;
      st_d = st_q;
      st_d.o.invalid_err = 1'b0;
      st_d.unsup = (row_w_sel_in == 2'h3) || (col_w_sel_in == 2'h3)
                   || (row_w_sel_in == 2'h0 && col_w_sel_in == 2'h2)
                   || (row_w_sel_in == 2'h2 && col_w_sel_in == 2'h0);
      st_d.o.page_kb = 4'h2 + 4'(col_w_sel_in) - 4'(bus32);
      if (req_in) begin
         st_d.o.valid = in_b0 || in_b1;
         st_d.o.cs0   = in_b0;
         st_d.o.cs1   = in_b1;
         st_d.o.leaf  = 2'(addr_in >> leaf_lsb);
         // Row map; unused high lines keep their bits
         st_d.o.row = {addr_in[27], addr_in[25], addr_in[23:12]};
         case (dec)
            DDRAD_DEC1: st_d.o.row = {addr_in[27], addr_in[25], addr_in[23:12]};
            DDRAD_DEC2: st_d.o.row[12] = addr_in[24];
            DDRAD_DEC3: st_d.o.row[13] = addr_in[26];
            default:    st_d.o.row = {addr_in[27], addr_in[25], addr_in[23:12]};
         endcase
         // Any column in the open page may start a burst
         st_d.o.col = {2'h0, addr_in[26], precharge_in, addr_in[24], addr_in[11:3]};
         st_d.last_col = {addr_in[24], addr_in[11:6]};
         // Narrow split only on a 64-bit bus with a nonzero size
         st_d.o.narrow = 1'b0;
         if (bus32) begin
            st_d.o.narrow = 1'b1;
         end else if (in_b0 && narrow_region_size_in != NARROW_RST) begin
            if (off < narrow_bytes) begin
               st_d.o.narrow = 1'b1;
            end else if (off < {narrow_bytes[30:0], 1'b0}) begin
               st_d.o.invalid_err = 1'b1;
            end
         end
      end else if (burst_in) begin
         // Low column bits wrap within the page; sequential advance of one burst
         st_d.o.col[8:0] = st_q.o.col[8:0] + {7'h0, BURST_LEN} + 9'h1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   always_comb begin
      hit_out                = st_q.o.valid;
      cs_n_out               = ~{st_q.o.cs1, st_q.o.cs0};
      leaf_out               = st_q.o.leaf;
      row_out                = st_q.o.row;
      dram_address_lines_out = st_q.o.col;
      narrow_out             = st_q.o.narrow;
      invalid_err_out        = st_q.o.invalid_err;
      page_kb_log2_out       = st_q.o.page_kb;
      unsupported_out        = st_q.unsup;
   end

   // ==================================================
   // Checks
   bank_excl_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      !(st_q.o.cs0 && st_q.o.cs1)) else $error("both banks selected");
   bank0_sel_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && in_b0 |=> !cs_n_out[0]) else $error("bank 0 not selected");
   miss_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && !bit31_ok |=> !hit_out) else $error("hit despite bit 31 mismatch");
   col_map_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in |=> dram_address_lines_out[9] == $past(addr_in[24])
      && dram_address_lines_out[11] == $past(addr_in[26])) else $error("column map wrong");
   row_low_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in |=> row_out[11:0] == $past(addr_in[23:12])) else $error("row map wrong");
   burst_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      !req_in && burst_in |=> dram_address_lines_out[8:0] == $past(st_q.o.col[8:0]) + 9'h4)
      else $error("burst step wrong");
   wide32_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && bus32 |=> narrow_out && !invalid_err_out) else $error("32-bit bus not narrow");
   err_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      invalid_err_out |-> !narrow_out && !cs_n_out[0]) else $error("error outside bank 0");
   no_split_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && !bus32 && narrow_region_size_in == 10'h0 |=> !narrow_out && !invalid_err_out)
      else $error("split without size");

   // ==================================================
   // Bank select checks, written partly from in_b0/in_b1 and partly from the base and limits

   bank1_sel_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && in_b1
      |=> !cs_n_out[1] && cs_n_out[0] && hit_out)
      else $error("bank 1 not selected");

   none_sel_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && !in_b0 && !in_b1
      |=> cs_n_out == 2'b11 && !hit_out)
      else $error("select outside both banks");

   hit_cs_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      1'b1
      |-> hit_out == (cs_n_out != 2'b11))
      else $error("hit and chip selects disagree");

   above_top_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && bit31_ok && {1'b0, addr_in[30:GRAN_LSB]} >= bank1_upper_limit_in
      |=> !hit_out)
      else $error("hit above bank 1 limit");

   below_base_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && addr_in[30:GRAN_LSB] < memory_base_value_in[5:0]
      |=> cs_n_out[0])
      else $error("bank 0 selected below base");

   // ==================================================
   // Leaf select checks at fixed geometries

   leaf_64m_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && !bus32 && row_w_sel_in == 2'h0 && col_w_sel_in == 2'h0
      |=> leaf_out == $past(addr_in[25:24]))
      else $error("leaf pair wrong for 64M");

   leaf_256m_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && !bus32 && row_w_sel_in == 2'h1 && col_w_sel_in == 2'h1
      |=> leaf_out == $past(addr_in[27:26]))
      else $error("leaf pair wrong for 256M");

   leaf_1g_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && !bus32 && row_w_sel_in == 2'h2 && col_w_sel_in == 2'h2
      |=> leaf_out == $past(addr_in[29:28]))
      else $error("leaf pair wrong for 1G");

   leaf_half_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && bus32 && row_w_sel_in == 2'h0 && col_w_sel_in == 2'h0
      |=> leaf_out == $past(addr_in[24:23]))
      else $error("leaf pair not halved on 32-bit bus");

   // ==================================================
   // Decode variant and row map checks

   dec2_pick_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      row_w_sel_in == 2'h1 && col_w_sel_in == 2'h0
      |-> dec == DDRAD_DEC2)
      else $error("13x9 not on decode 2");

   dec3_pick_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      row_w_sel_in == 2'h2 && col_w_sel_in == 2'h1
      |-> dec == DDRAD_DEC3)
      else $error("14x10 not on decode 3");

   dec1_pick_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      !(row_w_sel_in == 2'h1 && col_w_sel_in == 2'h0) && !(row_w_sel_in == 2'h2 && col_w_sel_in == 2'h1)
      |-> dec == DDRAD_DEC1)
      else $error("other geometry not on decode 1");

   row_dec1_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && dec == DDRAD_DEC1
      |=> row_out[13] == $past(addr_in[27]) && row_out[12] == $past(addr_in[25]))
      else $error("decode 1 row high lines wrong");

   row_dec2_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && dec == DDRAD_DEC2
      |=> row_out[12] == $past(addr_in[24]) && row_out[13] == $past(addr_in[27]))
      else $error("decode 2 row high lines wrong");

   row_dec3_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && dec == DDRAD_DEC3
      |=> row_out[13] == $past(addr_in[26]) && row_out[12] == $past(addr_in[25]))
      else $error("decode 3 row high lines wrong");

   row_unused_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && row_w_sel_in == 2'h0 && col_w_sel_in == 2'h0
      |=> row_out[13] == $past(addr_in[27]))
      else $error("unused row line not driven");

   // ==================================================
   // Column map and burst checks

   col_fixed_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in
      |=> dram_address_lines_out[13:12] == 2'b00 && dram_address_lines_out[10] == $past(precharge_in))
      else $error("column fixed lines wrong");

   col_low_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in
      |=> dram_address_lines_out[8:0] == $past(addr_in[11:3]))
      else $error("random start column wrong");

   col_hold_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      !req_in && !burst_in
      |=> $stable(dram_address_lines_out))
      else $error("column moved without burst");

   burst_row_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      !req_in && burst_in
      |=> $stable(row_out) && $stable(dram_address_lines_out[13:9]))
      else $error("burst touched row or high column");

   // ==================================================
   // Page size and geometry checks

   page_4k_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      !bus32 && col_w_sel_in == 2'h0
      |=> page_kb_log2_out == 4'h2)
      else $error("page not 4KB");

   page_16k_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      !bus32 && col_w_sel_in == 2'h2
      |=> page_kb_log2_out == 4'h4)
      else $error("page not 16KB");

   page_half_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      bus32 && col_w_sel_in == 2'h1
      |=> page_kb_log2_out == 4'h2)
      else $error("page not halved on 32-bit bus");

   unsup_geo_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (row_w_sel_in == 2'h0 && col_w_sel_in == 2'h2) || row_w_sel_in == 2'h3
      |=> unsupported_out)
      else $error("unsupported geometry not flagged");

   sup_geo_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      row_w_sel_in == 2'h1 && col_w_sel_in == 2'h1
      |=> !unsupported_out)
      else $error("supported geometry flagged");

   // ==================================================
   // Region split checks

   narrow_in_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && !bus32 && in_b0 && narrow_region_size_in != 10'h000 && (addr_in - base_addr) < narrow_bytes
      |=> narrow_out && !invalid_err_out)
      else $error("narrow region not 32-bit");

   wide_top_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && !bus32 && in_b0 && (addr_in - base_addr) >= {narrow_bytes[30:0], 1'b0}
      |=> !narrow_out && !invalid_err_out)
      else $error("upper bank 0 not 64-bit");

   b1_wide_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      req_in && !bus32 && in_b1
      |=> !narrow_out && !invalid_err_out)
      else $error("bank 1 split");

   err_idle_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      !req_in
      |=> !invalid_err_out)
      else $error("error without request");

   err_hit_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      invalid_err_out
      |-> hit_out)
      else $error("error without bank hit");

   // Main scenarios
   dec3_c: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) req_in && dec == DDRAD_DEC3);
   burst_c: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) !req_in && burst_in);
   hit_b1_c: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) !cs_n_out[1]);
   err_c: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) invalid_err_out);
   narrow_c: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) narrow_out && hit_out);
endmodule
`default_nettype wire

// [logic/ddrad_pkg.sv]
// Constants and carriers for the DDR address decode stage.
// Assumes one 20 MHz clock domain; configuration values are static while decoding.
// How it works
// - Banks 64MB to 1GB each, total 64MB to 2GB, from row/column widths.
// - Page size 4/8/16KB for 9/10/11 columns; halved on 32-bit bus.
// - Leaf selects come from address bits 25:24 for 64M, moving up per doubling.
// - On a 32-bit bus each leaf-select pairing covers half the bank size.
// - Geometry picks decode 1, 2 (13x9) or 3 (14x10).
// - Default row: bit27 on line 13, bit25 on 12, bits 23:12 on 11:0.
// - Column: bit26 on 11, precharge line on 10, bit24 on 9, bits 11:3 on 8:0.
// - Decode 2 puts bit 24 on row line 12.
// - Decode 3 puts bit 26 on row line 13.
// - Unused address lines still carry their mapped address bits.
// - Column address advances by four per burst.
// - Random bursts may start anywhere in the open page; sequential also supported.
// - Base gives upper seven bits; limits in 32MB granules.
// - Bank select from bit 31 match and bits 30:25 against base and limits.
// - After reset bank 0 is one 64-bit region.
// - Nonzero narrow size splits bank 0: 32-bit, invalid, 64-bit regions.
// - Invalid-region access is flagged as an error and interrupt request.
// - A 32-bit bus makes all space 32-bit and ignores narrow size.
// - Control word bit 2 selects bus width, default 64-bit.
package ddrad_pkg;
   localparam int          ROW_W_MIN      = 12;
   localparam int          ROW_W_MAX      = 14;
   localparam int          COL_W_MIN      = 9;
   localparam int          COL_W_MAX      = 11;
   localparam int          GRAN_LSB       = 25;
   localparam int          LEAF_LSB_64M   = 24;
   localparam int          NARROW_LSB     = 20;
   localparam int          WIDTH_CTRL_BIT = 2;
   localparam logic [1:0]  BURST_LEN      = 2'h3;
   localparam logic [9:0]  NARROW_RST     = 10'h000;
   localparam logic [6:0]  LIMIT_RST      = 7'h00;

   typedef enum logic [2:0] {
      DDRAD_DEC1 = 3'b001,
      DDRAD_DEC2 = 3'b010,
      DDRAD_DEC3 = 3'b100
   } ddrad_dec_e;

   typedef struct packed {
      logic        valid;
      logic        cs0;
      logic        cs1;
      logic        narrow;
      logic        invalid_err;
      logic [1:0]  leaf;
      logic [13:0] row;
      logic [13:0] col;
      logic [3:0]  page_kb;
   } ddrad_out_s;
endpackage

// [verif/ddrad_cfg_model.sv]
// Software-side partner: turns bank size codes into the two bank limits.
// Assumes a 32 MB aligned base whose space stays below a 2 GB boundary.
`timescale 1ns/1ps
`default_nettype none
module ddrad_cfg_model
   import ddrad_pkg::*;
(
   input  wire logic [6:0] base_in,  // Base bits 31:25
   input  wire logic [6:0] code0_in, // Bank 0 size code
   input  wire logic [6:0] code1_in, // Bank 1 size code
   output var  logic [6:0] lim0_out, // Bank 0 upper limit
   output var  logic [6:0] lim1_out  // Bank 1 upper limit
);
   // Chained so the banks stay contiguous and the limits never fall below the base
   assign lim0_out = code0_in + {1'b0, base_in[5:0]};
   assign lim1_out = code1_in + lim0_out;
endmodule
`default_nettype wire

// [verif/ddrad_decode_tb.sv]
// Self-checking bench for the address decode stage.
// Assumes outputs are registered one cycle after the request edge.
`timescale 1ns/1ps
`default_nettype none
module ddrad_decode_tb import ddrad_pkg::*;;
   localparam logic [31:0] A = 32'h0b5a_cff0;
   logic        clk = 1'b0, rst_n = 1'b0, req = 1'b0, bst = 1'b0, pre = 1'b0, hit, nar, inv, uns;
   logic [31:0] addr = 32'h0, ctl = 32'h0;
   logic [6:0]  base = 7'h00, c0 = 7'h02, c1 = 7'h04, l0, l1;
   logic [9:0]  nsz = 10'h000;
   logic [1:0]  rs = 2'h0, cw = 2'h0, cs_n, leaf;
   logic [13:0] row, col;
   logic [3:0]  pg;
   int          num_errors = 0, tests_run = 0, cyc = 0;
   ddrad_cfg_model cfg (.base_in(base), .code0_in(c0), .code1_in(c1), .lim0_out(l0), .lim1_out(l1));
   ddrad_decode uut (.sys_clk_in(clk), .reset_n_in(rst_n), .req_in(req), .addr_in(addr), .burst_in(bst),
      .precharge_in(pre), .memory_control_word_in(ctl), .memory_base_value_in(base),
      .bank0_upper_limit_in(l0), .bank1_upper_limit_in(l1), .narrow_region_size_in(nsz),
      .row_w_sel_in(rs), .col_w_sel_in(cw), .hit_out(hit), .cs_n_out(cs_n), .leaf_out(leaf),
      .row_out(row), .dram_address_lines_out(col), .narrow_out(nar), .invalid_err_out(inv),
      .page_kb_log2_out(pg), .unsupported_out(uns));
   // ==========================================================
   // Clock, timeout and reporting
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         complete_run();
      end
   end
   task complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // Inputs change on the falling edge; outputs are read one cycle after the request
   task go(input logic [31:0] a);
      @(negedge clk);
      req = 1'b1;
      addr = a;
      @(negedge clk);
      req = 1'b0;
   endtask
   function automatic logic [13:0] xrow(input logic [31:0] a, input int d);
      xrow = {(d == 3) ? a[26] : a[27], (d == 2) ? a[24] : a[25], a[23:12]};
   endfunction
   // ==========================================================
   // Scenarios
   task bsel(input logic [31:0] a, input logic [1:0] e);
      go(a);
      chk(cs_n, e);
      chk(hit, e != 2'h3);
   endtask
   task geo(input logic [1:0] r, input logic [1:0] c, input int d);
      rs = r;
      cw = c;
      go(A);
      chk(row, xrow(A, d));
      chk(col, {2'b00, A[26], pre, A[24], A[11:3]});
      chk(leaf, 2'(A >> (24 + r + c - ctl[2])));
      chk(pg, 2 + c - ctl[2]);
      chk(uns, 1'b0);
   endtask
   task uchk(input logic [1:0] r, input logic [1:0] c);
      rs = r;
      cw = c;
      @(negedge clk);
      chk(uns, 1'b1);
   endtask
   task nreg(input logic [31:0] a, input logic n, input logic i);
      go(a);
      chk(nar, n);
      chk(inv, i);
   endtask
   task t_burst;
      go(A);
      @(negedge clk);
      bst = 1'b1;
      @(negedge clk);
      bst = 1'b0;
      chk(col[8:0], 9'h002);
      chk(row, xrow(A, 1));
      go(A ^ 32'h0000_0100);
      chk(col[8:0], A[11:3] ^ 9'h020);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      chk(cs_n, 2'h3);
      chk(nar, 1'b0);
      bsel(32'h0000_0000, 2'h2);
      bsel(32'h03ff_ffff, 2'h2);
      bsel(32'h0400_0000, 2'h1);
      bsel(32'h0bff_ffff, 2'h1);
      bsel(32'h0c00_0000, 2'h3);
      bsel(32'h8000_0000, 2'h3);
      base = 7'h40;
      bsel(32'h8000_0000, 2'h2);
      bsel(32'h0000_0000, 2'h3);
      base = 7'h00;
      geo(2'h0, 2'h0, 1);
      geo(2'h1, 2'h0, 2);
      geo(2'h2, 2'h1, 3);
      pre = 1'b1;
      geo(2'h1, 2'h2, 1);
      pre = 1'b0;
      uchk(2'h0, 2'h2);
      uchk(2'h2, 2'h0);
      uchk(2'h3, 2'h0);
      nreg(32'h0040_0000, 1'b0, 1'b0);
      nsz = 10'h004;
      nreg(32'h0000_0000, 1'b1, 1'b0);
      nreg(32'h003f_ffff, 1'b1, 1'b0);
      nreg(32'h0040_0000, 1'b0, 1'b1);
      @(negedge clk);
      chk(inv, 1'b0);
      nreg(32'h007f_ffff, 1'b0, 1'b1);
      nreg(32'h0080_0000, 1'b0, 1'b0);
      ctl = 32'h0000_0004;
      geo(2'h0, 2'h0, 1);
      nreg(32'h0040_0000, 1'b1, 1'b0);
      ctl = 32'h0;
      t_burst();
      complete_run();
   end
endmodule
`default_nettype wire
